// file: rtl/rcc_top.sv
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_top #(
    parameter int WARM_CYC = `RCC_WARM_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // reset sources
    input  wire logic        low_voltage_detector_i,
    input  wire logic        wdt_overflow_i,
    input  wire logic        ext_reset_n_i,
    // clock sources
    input  wire logic        hosc_tick_i,
    input  wire logic        internal_rc_oscillator_tick_i,
    // outputs
    output logic             sys_reset_o,
    output logic             reg_init_o,
    output logic             pc_zero_o,
    output logic             cpu_tick_o,
    output logic             irq_o
);

    // every check below runs on the one clock, quiet while in reset
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // two-stage synchronisers for the pin and detector
    logic [1:0] pin_sync_q;
    logic [1:0] lvd_sync_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_q <= 2'b11;
            lvd_sync_q <= 2'b11;
        end else begin
            pin_sync_q <= {pin_sync_q[0], ext_reset_n_i};
            lvd_sync_q <= {lvd_sync_q[0], low_voltage_detector_i};
        end
    end

    logic [7:0] ctrl_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_en_q;
    logic [1:0] cause_q;
    logic       por_q;
    rcc_pkg::rcc_state_e state_q;
    logic [31:0] cnt_q;

    wire lvd_s = lvd_sync_q[1];
    wire pin_en = ctrl_q[`RCC_CTRL_PIN_EN];
    wire pin_low = pin_en & ~pin_sync_q[1];
    wire rst_req = lvd_s | wdt_overflow_i | pin_low;

    // sequencer: hold, init, warm up, run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= rcc_pkg::ST_HOLD;
            cnt_q   <= '0;
        end else if (rst_req) begin
            state_q <= rcc_pkg::ST_HOLD;
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                rcc_pkg::ST_HOLD: begin
                    state_q <= rcc_pkg::ST_INIT;
                    cnt_q   <= '0;
                end
                rcc_pkg::ST_INIT: begin
                    if (cnt_q == 32'(`RCC_INIT_CYC - 1)) begin
                        state_q <= rcc_pkg::ST_WARM;
                        cnt_q   <= '0;
                    end else begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                rcc_pkg::ST_WARM: begin
                    if (cnt_q == 32'(WARM_CYC - 1)) begin
                        state_q <= rcc_pkg::ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 32'd1;
                    end
                end
                rcc_pkg::ST_RUN: begin
                    state_q <= rcc_pkg::ST_RUN;
                end
                default: state_q <= rcc_pkg::ST_HOLD;
            endcase
        end
    end

    // capture cause, priority supply over watchdog over pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_q <= `RCC_CAUSE_POR;
        end else if (lvd_s) begin
            cause_q <= `RCC_CAUSE_POR;
        end else if (wdt_overflow_i) begin
            cause_q <= `RCC_CAUSE_WDT;
        end else if (pin_low) begin
            cause_q <= `RCC_CAUSE_PIN;
        end
    end

    wire in_run = (state_q == rcc_pkg::ST_RUN);
    assign sys_reset_o = ~in_run;
    assign reg_init_o  = (state_q == rcc_pkg::ST_INIT);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_q     <= 1'b0;
            pc_zero_o <= 1'b0;
        end else begin
            por_q     <= in_run;
            pc_zero_o <= in_run & ~por_q;
        end
    end

    // instruction clock divider
    wire       slow   = ctrl_q[`RCC_CTRL_SLOW];
    wire [2:0] div_f  = ctrl_q[`RCC_CTRL_DIV_LSB +: 3];
    wire [2:0] div_m1 = (ctrl_q[`RCC_CTRL_NFILT] && div_f < `RCC_NF_MIN_DIV)
                        ? `RCC_NF_MIN_DIV : div_f;
    wire       src_tick = slow ? internal_rc_oscillator_tick_i : hosc_tick_i;
    wire [3:0] div_top = slow ? (`RCC_SLOW_DIV - 4'd1) : {1'b0, div_m1};
    logic [3:0] div_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !in_run) begin
            div_q      <= 4'h0;
            cpu_tick_o <= 1'b0;
        end else if (src_tick) begin
            div_q      <= (div_q >= div_top) ? 4'h0 : div_q + 4'h1;
            cpu_tick_o <= (div_q >= div_top);
        end else begin
            cpu_tick_o <= 1'b0;
        end
    end

    // wishbone decode, one wait state then ack
    wire req    = cyc_i & stb_i & ~ack_o;
    wire wr     = req & we_i & sel_i[0];
    // one address compare, shared by every write decode
    function automatic logic addr_hit(input logic [3:0] a,
                                      input logic [3:0] off);
        addr_hit = (a == off);
    endfunction
    wire hit_c  = addr_hit(adr_i, `RCC_OFF_CTRL);
    wire hit_e  = addr_hit(adr_i, `RCC_OFF_IRQ_EN);
    wire hit_s  = addr_hit(adr_i, `RCC_OFF_IRQ_CLR);
    // events: supply, watchdog, pin
    wire [2:0] ev = {pin_low, wdt_overflow_i, lvd_s};
    wire [2:0] clr = (wr & hit_s) ? dat_i[2:0] : 3'b000;
    rcc_pkg::rcc_status_s st;
    assign st = '{cause: cause_q, in_reset: ~in_run, slow: slow};

    // registers; set beats clear on the sticky bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q     <= `RCC_CTRL_RST;
            irq_en_q   <= 3'b000;
            irq_stat_q <= 3'b000;
            ack_o      <= 1'b0;
            dat_o      <= 32'h0;
        end else begin
            ack_o      <= req;
            irq_stat_q <= (irq_stat_q & ~clr) | ev;
            if (wr && hit_c) ctrl_q <= dat_i[7:0];
            if (wr && hit_e) irq_en_q <= dat_i[2:0];
            unique case (adr_i)
                `RCC_OFF_CTRL:     dat_o <= {24'h0, ctrl_q};
                `RCC_OFF_STAT:     dat_o <= {st.cause, 4'h0, st.in_reset,
                                             st.slow, 24'h0};
                `RCC_OFF_IRQ_STAT: dat_o <= {29'h0, irq_stat_q};
                `RCC_OFF_IRQ_EN:   dat_o <= {29'h0, irq_en_q};
                default:           dat_o <= 32'h0;
            endcase
        end
    end

    assign irq_o = |(irq_stat_q & irq_en_q);

    // checker helpers: they only watch the logic and drive no output
    // divider setting, so that a change mid-stream can be spotted
    logic [3:0] cfg_q;
    wire  [3:0] cfg_now = {slow, div_top[2:0]};
    wire        cfg_chg = (cfg_now != cfg_q);
    // source ticks since the last instruction tick
    logic [3:0] src_cnt_q;
    logic       gap_valid_q;
    // cycles spent in the init phase
    logic [3:0] init_len_q;

    // setting history; a change voids one period of the gap check,
    // since the divider count may sit above the new top
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= 4'h0;
        end else begin
            cfg_q <= cfg_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !in_run || cfg_chg) begin
            src_cnt_q   <= 4'h0;
            gap_valid_q <= 1'b0;
        end else if (cpu_tick_o) begin
            src_cnt_q   <= {3'h0, src_tick};
            gap_valid_q <= 1'b1;
        end else begin
            src_cnt_q <= src_cnt_q + {3'h0, src_tick};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != rcc_pkg::ST_INIT) begin
            init_len_q <= 4'h0;
        end else begin
            init_len_q <= init_len_q + 4'h1;
        end
    end

    // assertions, on the default clock and reset above
    // detector forces reset
    lvd_reset_a: assert property (lvd_s |=> sys_reset_o)
        else $error("lvd did not reset");
    wdt_reset_a: assert property (
        wdt_overflow_i |=> state_q == rcc_pkg::ST_HOLD)
        else $error("wdt did not reset");
    supply_hold_a: assert property (lvd_s |=> !in_run)
        else $error("ran with bad supply");
    pin_off_a: assert property (
        (!pin_en && !lvd_s && !wdt_overflow_i && in_run) |=> in_run)
        else $error("pin reset while off");
    pin_low_a: assert property (
        pin_low |=> state_q == rcc_pkg::ST_HOLD)
        else $error("pin low ignored");
    pin_seq_a: assert property (
        (pin_low && !in_run) |=> state_q == rcc_pkg::ST_HOLD)
        else $error("pin ignored in start-up");
    pin_wait_a: assert property (
        (state_q == rcc_pkg::ST_HOLD && pin_low) |=> !reg_init_o)
        else $error("left hold with pin low");
    seq_order_a: assert property (
        $rose(in_run) |-> $past(state_q) == rcc_pkg::ST_WARM)
        else $error("run without warm up");
    init_len_a: assert property (
        (state_q == rcc_pkg::ST_WARM && $past(state_q) == rcc_pkg::ST_INIT)
        |-> init_len_q == `RCC_INIT_CYC)
        else $error("init phase length");
    pc_pulse_a: assert property (pc_zero_o |=> !pc_zero_o)
        else $error("start pulse too long");
    src_sel_a: assert property (
        (in_run && !slow && !hosc_tick_i) |=> !cpu_tick_o)
        else $error("tick from wrong source");
    slow_div_a: assert property (slow |-> div_top == 4'd3)
        else $error("slow div wrong");
    slow_gap_a: assert property (
        (cpu_tick_o && gap_valid_q && !cfg_chg && slow)
        |-> src_cnt_q == `RCC_SLOW_DIV)
        else $error("slow tick spacing");
    tick_gap_a: assert property (
        (cpu_tick_o && gap_valid_q && !cfg_chg && !slow)
        |-> src_cnt_q == div_top + 4'd1)
        else $error("normal tick spacing");
    nf_min_a: assert property (
        ctrl_q[`RCC_CTRL_NFILT] |-> div_m1 >= 3'd3)
        else $error("noise filter div");
    cause_wdt_a: assert property (
        (wdt_overflow_i && !lvd_s) |=> cause_q == `RCC_CAUSE_WDT)
        else $error("cause not wdt");
    cause_pin_a: assert property (
        (pin_low && !lvd_s && !wdt_overflow_i) |=> cause_q == `RCC_CAUSE_PIN)
        else $error("cause not pin");
    // events are kept; set beats a clear in the same cycle
    sticky_a: assert property (|ev |=> |irq_stat_q)
        else $error("event lost");
    set_wins_a: assert property ((ev[0] && clr[0]) |=> irq_stat_q[0])
        else $error("clear beat the event");
    // bus answer is a single pulse
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    run_c:  cover property (@(posedge clk_i) $rose(in_run));
    wdt_c:  cover property (@(posedge clk_i) in_run && wdt_overflow_i);
    pin_c:  cover property (@(posedge clk_i) in_run && pin_low);
    irq_c:  cover property (@(posedge clk_i) $rose(irq_o));
    slow_c: cover property (@(posedge clk_i) in_run && slow && cpu_tick_o);
endmodule

// file: rtl/rcc_consts.svh
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
// Summary of operation
// - low voltage forces full system reset
// - watchdog overflow forces full system reset
// - stay in reset while supply invalid
// - reset pin acts only when enabled
// - reset pin low holds reset
// - reset pin acts at power-up and run
// - power-up waits for reset pin high (here only once pin_en is set, and ctrl_q resets it to 0)
// - init registers, warm up, start at zero
// - select high or low clock source
// - slow mode divides low clock by four
// - normal mode divides high clock by N
// - noise filter forbids divisor below four
// - cause flags record last reset source

// register byte offsets
`define RCC_OFF_CTRL      4'h0
`define RCC_OFF_STAT      4'h4
`define RCC_OFF_IRQ_STAT  4'h8
`define RCC_OFF_IRQ_EN    4'hc
`define RCC_OFF_IRQ_CLR   4'h8
// control fields
`define RCC_CTRL_SLOW     0
`define RCC_CTRL_PIN_EN   1
`define RCC_CTRL_NFILT    2
`define RCC_CTRL_DIV_LSB  4
`define RCC_CTRL_RST      8'h00
// cause codes, bit 7 timeout_flag_n, bit 6 powerdown_flag_n
`define RCC_CAUSE_WDT     2'b00
`define RCC_CAUSE_POR     2'b10
`define RCC_CAUSE_PIN     2'b11
// timing
`define RCC_INIT_CYC      4'd8
`define RCC_WARM_US       1000
`define RCC_CLK_MHZ       20
`define RCC_WARM_CYC      (`RCC_WARM_US * `RCC_CLK_MHZ)
`define RCC_SLOW_DIV      4'd4
`define RCC_NF_MIN_DIV    3'd3
`endif

// file: rtl/rcc_pkg.sv
package rcc_pkg;
    typedef enum logic [2:0] {
        ST_HOLD,
        ST_INIT,
        ST_WARM,
        ST_RUN
    } rcc_state_e;
    typedef struct packed {
        logic [1:0] cause;
        logic       in_reset;
        logic       slow;
    } rcc_status_s;
endpackage

// file: verif/rcc_sup.sv
`timescale 1ns/1ps
// reset supervisor holding the active-low reset pin
module rcc_sup (
    // clock and request
    input  wire logic clk_i,
    input  wire logic hold_i,
    // reset pin
    output logic      ext_reset_n_o
);
    logic [2:0] dly_q = 3'h0;
    // late pin release
    // pin starts low and rises only after a delay, as a slow rc would
    always_ff @(posedge clk_i) begin
        dly_q         <= hold_i ? 3'h0 : dly_q + {2'h0, dly_q != 3'h7};
        ext_reset_n_o <= (dly_q == 3'h7);
    end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, low_voltage_detector = 1'b0;
    logic        wdt = 1'b0, hold = 1'b0, hos = 1'b0, rc = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q, c;
    logic        ack, pin_n, srst, rinit, pcz, tick, irq;
    int          n_mismatch = 0, checked = 0, cyc_n = 0;

    rcc_top #(.WARM_CYC(10)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .low_voltage_detector_i(low_voltage_detector),
        .wdt_overflow_i(wdt), .ext_reset_n_i(pin_n),
        .hosc_tick_i(hos), .internal_rc_oscillator_tick_i(rc),
        .sys_reset_o(srst), .reg_init_o(rinit), .pc_zero_o(pcz),
        .cpu_tick_o(tick), .irq_o(irq));
    rcc_sup sup_u (.clk_i(clk_i), .hold_i(hold), .ext_reset_n_o(pin_n));

    always #25 clk_i = ~clk_i;
    // hang limit, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // classic cycle, held until ack is sampled
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
            output logic [31:0] r);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // follow one reset sequence to the program start
    task run(input logic [1:0] cs);
        logic [31:0] r, p;
        int i;
        r = 0;
        p = 0;
        for (i = 0; i < 300 && (i < 5 || srst !== 1'b0); i++) begin
            @(posedge clk_i);
            r += {31'h0, rinit === 1'b1};
            if (i == 4) chk("reset", 32'h1, {31'h0, srst});
        end
        repeat (3) begin
            @(posedge clk_i);
            p += {31'h0, pcz === 1'b1};
        end
        chk("init", 32'h8, r);
        chk("pc0", 32'h1, p);
        wb(1'b0, 4'h4, 32'h0, q);
        chk("cause", {30'h0, cs}, q >> 30);
        $display("test done: reset cause %b", cs);
    endtask
    // cycles between instruction ticks, the first gaps are discarded
    task gap(output logic [31:0] n);
        int i;
        repeat (3) begin
            n = 1;
            @(posedge clk_i);
            for (i = 0; i < 40 && tick !== 1'b1; i++) begin
                @(posedge clk_i);
                n++;
            end
        end
    endtask

    task results();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] e;
        logic        nf;
        void'($urandom(2));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        run(2'b10);
        wb(1'b1, 4'h8, 32'h7, q);
        wdt <= 1'b1;
        @(posedge clk_i);
        wdt <= 1'b0;
        run(2'b00);
        wb(1'b0, 4'h8, 32'h0, q);
        chk("irq_stat", 32'h2, q);
        chk("irq_off", 32'h0, {31'h0, irq});
        wb(1'b1, 4'hc, 32'h2, q);
        chk("irq_on", 32'h1, {31'h0, irq});
        wb(1'b1, 4'h8, 32'h2, q);
        chk("irq_clr", 32'h0, {31'h0, irq});
        // supply stays low across a watchdog reset
        low_voltage_detector <= 1'b1;
        wdt <= 1'b1;
        @(posedge clk_i);
        wdt <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk("held", 32'h1, {31'h0, srst});
        low_voltage_detector <= 1'b0;
        run(2'b10);
        hold <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk("pin_off", 32'h0, {31'h0, srst});
        wb(1'b1, 4'h0, 32'h2, q);
        hold <= 1'b0;
        run(2'b11);
        hos <= 1'b1;
        for (int n = 1; n <= 8; n++) begin
            nf = 1'($urandom % 2);
            wb(1'b1, 4'h0, {25'h0, 3'(n - 1), 1'b0, nf, 2'b00}, q);
            e = (nf && n < 4) ? 32'd4 : 32'(n);
            gap(c);
            chk("div", e, c);
        end
        hos <= 1'b0;
        rc  <= 1'b1;
        wb(1'b1, 4'h0, 32'h1, q);
        gap(c);
        chk("slow_div", 32'h4, c);
        wb(1'b0, 4'h4, 32'h0, q);
        chk("slow_bit", 32'h1, (q >> 24) & 32'h1);
        $display("test done: clock dividers");
        results();
    end
endmodule
